// File: fault_pkg.sv
// Shared constants, types and register layout for the output fault supervisor
package fault_pkg;

	// ==================================================
	// Clock and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int SHUTDOWN_MS = 10000;
	localparam int SHUTDOWN_CYCLES = SHUTDOWN_MS * CLK_KHZ;
	localparam int BLINK_MS = 500;
	localparam int BLINK_CYCLES = BLINK_MS * CLK_KHZ;

	// ==================================================
	// Trip levels (temperature in 0.1 C, voltage in mV, current in mA)
	localparam logic [19:0] TEMP_TRIP_DC = 20'h001c2;
	localparam logic [19:0] TEMP_HIGH_DC = 20'h00190;
	localparam logic [19:0] COMPLIANCE_MV = 20'h0abe0;
	localparam logic [19:0] CURRENT_TRIP_MA = 20'h11d28;
	localparam logic [19:0] OUTSTG_HIGH_MV = 20'h101d0;
	localparam logic [19:0] OUTSTG_LOW_MV = 20'h0abe0;
	localparam logic [19:0] PROG_LIMIT_MV = 20'h00019;

	// ==================================================
	// Register map and fields
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SETPOINT_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_USERCLR_BIT = 3;
	localparam int CTRL_MODESET_BIT = 4;
	localparam logic [19:0] SETPOINT_RST = 20'h00000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================
	// Error indices
	localparam int HW_TEMP = 0;
	localparam int HW_OVERV = 1;
	localparam int HW_OVERI = 2;
	localparam int HW_AUX = 3;
	localparam int HW_RAIL = 4;
	localparam int N_HW = 5;
	localparam int OP_REMOTE = 0;
	localparam int OP_SUPPLY = 1;
	localparam int OP_MAGNET = 2;
	localparam int N_OP = 3;

	// ==================================================
	// Types
	typedef enum logic [1:0] {MODE_INTERNAL, MODE_EXTERNAL, MODE_SUM, MODE_BAD} prog_mode_e;

	typedef struct packed {
		logic [19:0] cold_temp_dc;
		logic [19:0] out_volt_mv;
		logic [19:0] out_curr_ma;
		logic [19:0] outstg_volt_mv;
		logic [19:0] prog_volt_mv;
		logic remote_loop_closed;
		logic supply_flow_closed;
		logic magnet_flow_closed;
		logic aux_alive;
		logic aux_bad_reply;
		logic rails_in_range;
		logic cal_valid;
		logic cal_corrupt;
	} monitor_s;

	typedef struct packed {
		logic status_key;
		logic esc_key;
		logic enter_key;
	} keys_s;

	typedef struct packed {
		logic [13:0] rsvd;
		prog_mode_e mode;
		logic display;
		logic power_off;
		logic user_err;
		logic cal_invalid;
		logic ext_prog;
		logic low_line;
		logic high_line;
		logic temp_high;
		logic [2:0] op;
		logic [4:0] hw;
	} status_s;

endpackage

// File: error_latch.sv
// Sticky error flag, set by its condition and optionally cleared on request
`timescale 1ns/1ps
module error_latch #(
	parameter logic CLEARABLE = 1'h0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cond,
	input wire logic clear_req,
	output logic err
);

	logic next_err;

	// ==================================================
	// Next value: condition wins over any clear
	always_comb begin
		next_err = err;
		if (cond) begin
			next_err = 1'h1;
		end else if (CLEARABLE && clear_req) begin
			next_err = 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err <= 1'h0;
		end else begin
			err <= next_err;
		end
	end

	// ==================================================
	// Checks
	a_latch_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		cond |=> err) else $error("Error flag missed its condition");
	a_latch_clear_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(err) |-> CLEARABLE && $past(clear_req) && !$past(cond))
		else $error("Error flag cleared without clear or with condition present");
	a_latch_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		err && !clear_req |=> err) else $error("Error flag dropped by itself");

endmodule

// File: output_fault_supervisor.sv
// Fault supervisor for the magnet current supply output stage
//
// Function
// - Any shown error lights the fault lamp; user errors never do.
// - Hardware error: lamp solid, setpoint zero, entry blocked, cleared only by power cycle.
// - Operational error: lamp blinks; clears only after its condition is gone.
// - Unprocessable request answers at once with an error and leaves the lamp alone.
// - Status key opens error display; second press clears clearable errors.
// - Cold plate over 45 C: zero, block, flash ten seconds, then power off.
// - Output over 44 V compliance: zero, block, flash ten seconds, then power off.
// - Output current over 73 A: zero, block, flash ten seconds, then power off.
// - Auxiliary processor silent or wrong: zero and block until power cycle, no shutdown.
// - Monitored rail out of range at power-up: zero and block until power cycle.
// - Open remote-enable loop: zero, block; clear by key or host after closing.
// - Open supply flow loop: zero, block; clear by key or host once closed.
// - Open magnet flow loop: zero, block; clear by key or host once closed.
// - Output-stage supply above 66 V: warn, keep running, clear by itself.
// - Cold plate above 40 C: zero and block; clears itself below 40 C.
// - Refuse external or sum mode above 0.025 V; clear below it or on internal.
// - Missing or corrupt calibration flags error, still runs, escape plus enter clears.
// - Isolated fault relay follows the fault lamp at all times.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module output_fault_supervisor #(
	parameter int SHUTDOWN_CYCLES = fault_pkg::SHUTDOWN_CYCLES,
	parameter int BLINK_CYCLES = fault_pkg::BLINK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire fault_pkg::monitor_s mon,
	input wire fault_pkg::keys_s keys,
	input wire fault_pkg::prog_mode_e powerup_mode,
	output logic fault_led,
	output logic fault_relay,
	output logic entry_blocked,
	output logic [19:0] setpoint_out,
	output fault_pkg::prog_mode_e prog_mode,
	output logic msg_flash,
	output logic power_off,
	output logic status_display
);

	typedef enum logic [1:0] {SD_IDLE, SD_FLASH, SD_OFF} shut_e;

	logic first_cycle, next_first_cycle;
	logic display, next_display;
	logic [31:0] blink_cnt, next_blink_cnt;
	logic blink, next_blink;
	shut_e sd_state, next_sd_state;
	logic [31:0] sd_count, next_sd_count;
	logic temp_high, next_temp_high;
	logic high_line, next_high_line;
	logic low_line, next_low_line;
	logic ext_err, next_ext_err;
	logic cal_invalid, next_cal_invalid;
	logic user_err, next_user_err;
	fault_pkg::prog_mode_e mode, next_mode;
	logic [19:0] setpoint, next_setpoint;
	logic led, next_led;
	logic aw_held, next_aw_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic w_held, next_w_held;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic [fault_pkg::N_HW-1:0] hw_cond, hw_err;
	logic [fault_pkg::N_OP-1:0] op_cond, op_err;
	logic hw_any, op_show, blocked, shut_trip, key_clear, any_clear;
	logic do_write, wr_ctrl, wr_setp, wr_mapped, host_clear, user_clr;
	logic mode_set, bad_mode, setp_reject, user_evt, req_valid, prog_high, prog_low, cal_evt;
	fault_pkg::prog_mode_e req_mode;
	fault_pkg::status_s status;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;

	// ==================================================
	// Error conditions
	// cold plate trip
	assign hw_cond[fault_pkg::HW_TEMP] = mon.cold_temp_dc > fault_pkg::TEMP_TRIP_DC;
	assign hw_cond[fault_pkg::HW_OVERV] = mon.out_volt_mv > fault_pkg::COMPLIANCE_MV;
	assign hw_cond[fault_pkg::HW_OVERI] = mon.out_curr_ma > fault_pkg::CURRENT_TRIP_MA;
	assign hw_cond[fault_pkg::HW_AUX] = !mon.aux_alive || mon.aux_bad_reply;
	assign hw_cond[fault_pkg::HW_RAIL] = first_cycle && !mon.rails_in_range;
	assign op_cond[fault_pkg::OP_REMOTE] = !mon.remote_loop_closed;
	assign op_cond[fault_pkg::OP_SUPPLY] = !mon.supply_flow_closed;
	assign op_cond[fault_pkg::OP_MAGNET] = !mon.magnet_flow_closed;

	// ==================================================
	// Sticky error flags
	// hardware errors never clear
	for (genvar i = 0; i < fault_pkg::N_HW; i++) begin : g_hw
		error_latch #(.CLEARABLE(1'h0)) u_hw (
			.aclk(aclk),
			.aresetn(aresetn),
			.cond(hw_cond[i]),
			.clear_req(1'h0),
			.err(hw_err[i])
		);
	end
	for (genvar j = 0; j < fault_pkg::N_OP; j++) begin : g_op
		error_latch #(.CLEARABLE(1'h1)) u_op (
			.aclk(aclk),
			.aresetn(aresetn),
			.cond(op_cond[j]),
			.clear_req(any_clear),
			.err(op_err[j])
		);
	end

	// Summary terms
	assign hw_any = |hw_err;
	assign op_show = (|op_err) | temp_high | high_line | low_line | ext_err | cal_invalid;
	assign blocked = hw_any | (|op_err) | temp_high;
	assign shut_trip = hw_err[fault_pkg::HW_TEMP] | hw_err[fault_pkg::HW_OVERV]
		| hw_err[fault_pkg::HW_OVERI];
	assign key_clear = keys.status_key && display;
	assign any_clear = key_clear || host_clear;

	// ==================================================
	// Write decode
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_ctrl = do_write && (aw_addr == fault_pkg::CTRL_OFS) && w_strb[0];
	assign wr_setp = do_write && (aw_addr == fault_pkg::SETPOINT_OFS);
	assign wr_mapped = (aw_addr == fault_pkg::CTRL_OFS) || (aw_addr == fault_pkg::SETPOINT_OFS);
	assign host_clear = wr_ctrl && w_data[fault_pkg::CTRL_CLEAR_BIT];
	assign user_clr = wr_ctrl && w_data[fault_pkg::CTRL_USERCLR_BIT];
	assign mode_set = wr_ctrl && w_data[fault_pkg::CTRL_MODESET_BIT];
	assign bad_mode = mode_set
		&& (w_data[fault_pkg::CTRL_MODE_LSB +: 2] == 2'(fault_pkg::MODE_BAD));
	assign setp_reject = wr_setp && blocked;
	assign user_evt = bad_mode || setp_reject;
	assign req_valid = first_cycle || mode_set;
	assign req_mode = first_cycle ? powerup_mode
		: fault_pkg::prog_mode_e'(w_data[fault_pkg::CTRL_MODE_LSB +: 2]);
	assign prog_high = mon.prog_volt_mv > fault_pkg::PROG_LIMIT_MV;
	assign prog_low = mon.prog_volt_mv < fault_pkg::PROG_LIMIT_MV;
	assign cal_evt = (first_cycle && !mon.cal_valid) || mon.cal_corrupt;

	// ==================================================
	// Power-up marker, status display and blink timebase
	always_comb begin
		next_first_cycle = 1'h0;
		next_display = display;
		next_blink_cnt = blink_cnt + 32'h1;
		next_blink = blink;
		if (keys.status_key) begin
			next_display = !display;
		end
		if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
			next_blink_cnt = 32'h0;
			next_blink = !blink;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_cycle <= 1'h1;
			display <= 1'h0;
			blink_cnt <= 32'h0;
			blink <= 1'h0;
		end else begin
			first_cycle <= next_first_cycle;
			display <= next_display;
			blink_cnt <= next_blink_cnt;
			blink <= next_blink;
		end
	end

	// ==================================================
	// Self power-off sequence
	always_comb begin
		next_sd_state = sd_state;
		next_sd_count = sd_count;
		case (sd_state)
			SD_IDLE: begin
				// start flashing on a shutdown trip
				if (shut_trip) begin
					next_sd_state = SD_FLASH;
					next_sd_count = 32'h0;
				end
			end
			SD_FLASH: begin
				// switch off after the flash period
				if (sd_count == 32'(SHUTDOWN_CYCLES - 1)) begin
					next_sd_state = SD_OFF;
				end else begin
					next_sd_count = sd_count + 32'h1;
				end
			end
			SD_OFF: begin
				next_sd_state = SD_OFF;
			end
			default: begin
				next_sd_state = SD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sd_state <= SD_IDLE;
			sd_count <= 32'h0;
		end else begin
			sd_state <= next_sd_state;
			sd_count <= next_sd_count;
		end
	end

	// ==================================================
	// Warnings, mode, calibration, user error, setpoint and lamp
	always_comb begin
		next_temp_high = temp_high;
		if (mon.cold_temp_dc > fault_pkg::TEMP_HIGH_DC) begin
			next_temp_high = 1'h1;
		end else if (mon.cold_temp_dc < fault_pkg::TEMP_HIGH_DC) begin
			next_temp_high = 1'h0;
		end
		next_high_line = mon.outstg_volt_mv > fault_pkg::OUTSTG_HIGH_MV;
		next_low_line = mon.outstg_volt_mv < fault_pkg::OUTSTG_LOW_MV;
		next_mode = mode;
		next_ext_err = ext_err;
		// clears once programming input is low
		if (prog_low) begin
			next_ext_err = 1'h0;
		end
		if (req_valid) begin
			case (req_mode)
				fault_pkg::MODE_INTERNAL: begin
					next_mode = fault_pkg::MODE_INTERNAL;
					next_ext_err = 1'h0;
				end
				fault_pkg::MODE_EXTERNAL, fault_pkg::MODE_SUM: begin
					// refuse while programming input is high
					if (prog_high) begin
						next_ext_err = 1'h1;
					end else begin
						next_mode = req_mode;
					end
				end
				default: begin
					next_mode = mode;
				end
			endcase
		end
		// set on bad data, escape plus enter clears
		next_cal_invalid = cal_invalid;
		if (cal_evt) begin
			next_cal_invalid = 1'h1;
		end else if (keys.esc_key && keys.enter_key) begin
			next_cal_invalid = 1'h0;
		end
		// sticky user error, lamp not involved
		next_user_err = user_err;
		if (user_evt) begin
			next_user_err = 1'h1;
		end else if (user_clr) begin
			next_user_err = 1'h0;
		end
		next_setpoint = setpoint;
		if (blocked) begin
			next_setpoint = 20'h00000;
		end else if (wr_setp) begin
			for (int b = 0; b < 3; b++) begin
				if (w_strb[b]) begin
					next_setpoint[b*8 +: 4] = w_data[b*8 +: 4];
					if (b < 2) begin
						next_setpoint[b*8+4 +: 4] = w_data[b*8+4 +: 4];
					end
				end
			end
		end
		if (hw_any) begin
			next_led = 1'h1;
		end else if (op_show) begin
			next_led = blink;
		end else begin
			// lamp only while an error is shown
			next_led = 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_high <= 1'h0;
			high_line <= 1'h0;
			low_line <= 1'h0;
			ext_err <= 1'h0;
			cal_invalid <= 1'h0;
			user_err <= 1'h0;
			mode <= fault_pkg::MODE_INTERNAL;
			setpoint <= fault_pkg::SETPOINT_RST;
			led <= 1'h0;
		end else begin
			temp_high <= next_temp_high;
			high_line <= next_high_line;
			low_line <= next_low_line;
			ext_err <= next_ext_err;
			cal_invalid <= next_cal_invalid;
			user_err <= next_user_err;
			mode <= next_mode;
			setpoint <= next_setpoint;
			led <= next_led;
		end
	end

	// ==================================================
	// AXI4-Lite slave
	always_comb begin
		status = '0;
		status.hw = hw_err;
		status.op = op_err;
		status.temp_high = temp_high;
		status.high_line = high_line;
		status.low_line = low_line;
		status.ext_prog = ext_err;
		status.cal_invalid = cal_invalid;
		status.user_err = user_err;
		status.power_off = power_off;
		status.display = display;
		status.mode = mode;
		rd_resp = fault_pkg::RESP_OKAY;
		case (s_axi_araddr)
			fault_pkg::CTRL_OFS: rd_word = {27'h0, 2'(mode), 3'h0} << 0;
			fault_pkg::SETPOINT_OFS: rd_word = {12'h000, setpoint};
			fault_pkg::STATUS_OFS: rd_word = status;
			default: begin
				rd_word = 32'h0;
				rd_resp = fault_pkg::RESP_SLVERR;
			end
		endcase
	end

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'h1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'h1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'h0;
			next_w_held = 1'h0;
			next_bvalid = 1'h1;
			next_bresp = (wr_mapped && !user_evt) ? fault_pkg::RESP_OKAY : fault_pkg::RESP_SLVERR;
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'h0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'h1;
			next_rdata = rd_word;
			next_rresp = rd_resp;
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'h0;
			aw_addr <= 8'h00;
			w_held <= 1'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid <= 1'h0;
			bresp <= 2'h0;
			rvalid <= 1'h0;
			rdata <= 32'h0;
			rresp <= 2'h0;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// ==================================================
	// Outputs
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign fault_led = led;
	assign fault_relay = led;
	assign entry_blocked = blocked;
	assign setpoint_out = setpoint;
	assign prog_mode = mode;
	assign msg_flash = (sd_state == SD_FLASH) && blink;
	assign power_off = sd_state == SD_OFF;
	assign status_display = display;

	// ==================================================
	// Checks
	a_led_hw_solid: assert property (@(posedge aclk) disable iff (!aresetn)
		hw_any |=> fault_led) else $error("Lamp not solid with hardware error");
	a_led_op_blink: assert property (@(posedge aclk) disable iff (!aresetn)
		!hw_any && op_show |=> fault_led == $past(blink)) else $error("Lamp not blinking");
	a_led_idle_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!hw_any && !op_show |=> !fault_led) else $error("Lamp lit with no error");
	a_zero_setpoint: assert property (@(posedge aclk) disable iff (!aresetn)
		blocked |=> setpoint_out == 20'h00000) else $error("Setpoint not forced to zero");
	a_shutdown_time: assert property (@(posedge aclk) disable iff (!aresetn)
		sd_state == SD_FLASH && sd_count == 32'(SHUTDOWN_CYCLES - 1) |=> power_off)
		else $error("No power-off at end of flash period");
	a_no_early_off: assert property (@(posedge aclk) disable iff (!aresetn)
		sd_state == SD_IDLE |=> !power_off) else $error("Power-off without flash period");
	a_ext_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_set && prog_high && req_mode inside {fault_pkg::MODE_EXTERNAL, fault_pkg::MODE_SUM}
		&& mode == fault_pkg::MODE_INTERNAL |=> ext_err && prog_mode == fault_pkg::MODE_INTERNAL)
		else $error("External mode entered with programming input high");
	a_cal_keys_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		keys.esc_key && keys.enter_key && !cal_evt |=> !cal_invalid)
		else $error("Calibration flag not cleared by keys");
	a_high_line_auto: assert property (@(posedge aclk) disable iff (!aresetn)
		mon.outstg_volt_mv <= fault_pkg::OUTSTG_HIGH_MV |=> !high_line)
		else $error("High line warning stuck");
	a_user_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		setp_reject |=> s_axi_bvalid && s_axi_bresp == fault_pkg::RESP_SLVERR && user_err)
		else $error("Rejected setpoint write not answered with error");

endmodule

// File: keypad_model.sv
// Front-panel keypad model that presses keys for the bench
`timescale 1ns/1ps
module keypad_model (
	input wire logic aclk,
	output fault_pkg::keys_s keys
);
	// ==========
	// Key activity
	// Keys idle at start
	initial begin
		keys = '0;
	end
	// One status press is a single-cycle pulse
	task automatic status_press;
		@(posedge aclk);
		keys.status_key <= 1'h1;
		@(posedge aclk);
		keys.status_key <= 1'h0;
	endtask
	// Escape and enter held together for a few cycles
	task automatic both_press;
		@(posedge aclk);
		keys.esc_key <= 1'h1;
		keys.enter_key <= 1'h1;
		repeat (3) @(posedge aclk);
		keys.esc_key <= 1'h0;
		keys.enter_key <= 1'h0;
	endtask
endmodule

// File: output_fault_supervisor_tb.sv
// Self-checking bench for the output fault supervisor
`timescale 1ns/1ps
module output_fault_supervisor_tb;
	// ==========
	// Signals and instances
	logic aclk, aresetn, awv, wv, arv, awready, wready, bvalid, arready, rvalid;
	logic led, relay, blk, flash, poff, disp;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [19:0] sp;
	fault_pkg::monitor_s mon;
	fault_pkg::keys_s keys;
	fault_pkg::prog_mode_e mode;
	int n_fail, total_checks, fl;
	localparam logic [7:0] ST = fault_pkg::STATUS_OFS;
	localparam logic [7:0] SP = fault_pkg::SETPOINT_OFS;
	localparam logic [1:0] OK = fault_pkg::RESP_OKAY;
	localparam logic [1:0] ER = fault_pkg::RESP_SLVERR;
	keypad_model kp (.aclk(aclk), .keys(keys));
	output_fault_supervisor #(.SHUTDOWN_CYCLES(50), .BLINK_CYCLES(4)) uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1), .mon(mon),
		.keys(keys), .powerup_mode(fault_pkg::MODE_INTERNAL), .fault_led(led),
		.fault_relay(relay), .entry_blocked(blk), .setpoint_out(sp), .prog_mode(mode),
		.msg_flash(flash), .power_off(poff), .status_display(disp));
	// Clock source, 100 ns period
	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	// ==========
	// Tasks
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// One clock with a bound on the wait
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 100) begin
			n_fail++;
			wrap_up();
		end
	endtask
	// Bus write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= v;
		awv <= 1'h1;
		wv <= 1'h1;
		do begin
			tick(n);
			if (awready) awv <= 1'h0;
			if (wready) wv <= 1'h0;
		end while (bvalid !== 1'h1);
		chk("bresp", {30'h0, e}, {30'h0, bresp});
	endtask
	// Bus read compared with an expected word
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		// One edge first, so flags set by the last stimulus are in the captured word
		@(posedge aclk);
		araddr <= a;
		arv <= 1'h1;
		do begin
			tick(n);
			if (arready) arv <= 1'h0;
		end while (rvalid !== 1'h1);
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	// Lamp watch: relay must track it; solid or blinking
	task automatic lamp(input logic solid);
		int ones;
		ones = 0;
		repeat (12) begin
			@(posedge aclk);
			ones += int'(led === 1'h1);
			chk("relay", {31'h0, led}, {31'h0, relay});
		end
		chk("lamp", 32'h1, solid ? 32'(ones == 12) : 32'(ones > 0 && ones < 12));
	endtask
	// ==========
	// Main sequence
	initial begin
		n_fail = 0;
		total_checks = 0;
		aresetn = 1'h0;
		{awv, wv, arv, awaddr, araddr, wdata} = '0;
		mon = {20'h000fa, 20'h0, 20'h0, 20'h0bb80, 20'h0, 8'hf6};
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc(ST, 32'h0, OK);
		rc(8'h0c, 32'h0, ER);
		wr(SP, 32'h12345, OK);
		rc(SP, 32'h12345, OK);
		chk("sp", 32'h12345, {12'h0, sp});
		mon.remote_loop_closed <= 1'h0;
		repeat (3) @(posedge aclk);
		chk("blk", 32'h1, {31'h0, blk});
		chk("sp", 32'h0, {12'h0, sp});
		lamp(1'h0);
		wr(SP, 32'h00100, ER);
		wr(8'h00, 32'h1, OK);
		rc(ST, 32'h2020, OK);
		lamp(1'h0);
		mon.remote_loop_closed <= 1'h1;
		wr(8'h00, 32'h9, OK);
		rc(ST, 32'h0, OK);
		chk("led", 32'h0, {31'h0, led});
		mon.supply_flow_closed <= 1'h0;
		kp.status_press();
		repeat (2) @(posedge aclk);
		chk("disp", 32'h1, {31'h0, disp});
		kp.status_press();
		rc(ST, 32'h40, OK);
		mon.supply_flow_closed <= 1'h1;
		kp.status_press();
		kp.status_press();
		rc(ST, 32'h0, OK);
		mon.cold_temp_dc <= 20'h00191;
		rc(ST, 32'h100, OK);
		mon.cold_temp_dc <= 20'h0018f;
		rc(ST, 32'h0, OK);
		mon.outstg_volt_mv <= 20'h101d1;
		rc(ST, 32'h200, OK);
		chk("blk", 32'h0, {31'h0, blk});
		mon.outstg_volt_mv <= 20'h0abdf;
		rc(ST, 32'h400, OK);
		mon.outstg_volt_mv <= 20'h0bb80;
		mon.cal_corrupt <= 1'h1;
		rc(ST, 32'h1000, OK);
		mon.cal_corrupt <= 1'h0;
		kp.both_press();
		rc(ST, 32'h0, OK);
		// Mode requests: refused with programming input high, then taken, then a bad code
		mon.prog_volt_mv <= 20'h00030;
		wr(8'h00, 32'h12, OK);
		rc(ST, 32'h800, OK);
		chk("mode", 32'h0, {30'h0, mode});
		mon.prog_volt_mv <= 20'h00000;
		wr(8'h00, 32'h12, OK);
		rc(8'h00, 32'h8, OK);
		chk("mode", 32'h1, {30'h0, mode});
		wr(8'h00, 32'h16, ER);
		rc(ST, 32'h12000, OK);
		wr(8'h00, 32'h18, OK);
		rc(ST, 32'h0, OK);
		mon.remote_loop_closed <= 1'h0;
		mon.out_curr_ma <= 20'h11d29;
		mon.aux_bad_reply <= 1'h1;
		repeat (3) @(posedge aclk);
		lamp(1'h1);
		chk("poff", 32'h0, {31'h0, poff});
		mon.out_curr_ma <= 20'h0;
		mon.aux_bad_reply <= 1'h0;
		mon.remote_loop_closed <= 1'h1;
		// Message flashes during the shutdown period, then stops at power-off
		fl = 0;
		repeat (60) begin
			@(posedge aclk);
			fl += int'(flash === 1'h1);
		end
		chk("flash", 32'h1, 32'(fl > 0 && fl < 60));
		wr(8'h00, 32'h1, OK);
		rc(ST, 32'h400c, OK);
		chk("poff", 32'h1, {31'h0, poff});
		wrap_up();
	end
endmodule
